// ### bench/fieldbus_starter_command_adapter_test.sv
`timescale 1ns/100ps
module fieldbus_starter_command_adapter_test;
    import fsca_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, st_ready, st_op_mode, st_running;
    logic        st_tripped, st_warning, st_remote, run_req, motor_set_sel, cmd_strobe, trip_reset;
    logic        led_power, led_error, led_status;
    logic [1:0]  htrans, port_link, port_act, led_link, led_act;
    logic [31:0] haddr, hwdata, hrdata, st_current, q;
    logic [15:0] st_trip_code;
    int          error_cnt, comparisons, strobes, trips;

    fsca_adapter #(.INTERVAL_CYCLES(20), .FLASH_HALF_CYCLES(4), .ACT_HOLD_CYCLES(8), .NPORTS(2)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .irq(irq), .st_ready(st_ready), .st_op_mode(st_op_mode), .st_running(st_running),
        .st_tripped(st_tripped), .st_warning(st_warning), .st_remote(st_remote), .st_current(st_current),
        .st_trip_code(st_trip_code), .port_link(port_link), .port_act(port_act), .run_req(run_req),
        .motor_set_sel(motor_set_sel), .cmd_strobe(cmd_strobe), .trip_reset(trip_reset),
        .led_power(led_power), .led_error(led_error), .led_status(led_status), .led_link(led_link),
        .led_act(led_act));
    fsca_starter_model partner (.hclk(hclk), .hresetn(hresetn), .run_req(run_req), .trip_reset(trip_reset),
        .st_running(st_running), .st_tripped(st_tripped), .st_ready(st_ready));

    always #50 hclk = ~hclk;
    always @(posedge hclk) begin
        if (cmd_strobe === 1'b1)
            strobes++;
        if (trip_reset === 1'b1)
            trips++;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (3) @(posedge hclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
        xfer(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge hclk);
        error_cnt++;
        end_of_test;
    end
    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
        st_op_mode = 1; st_warning = 1; st_remote = 0; st_current = 32'h0001_0d42; st_trip_code = 16'h1234;
        port_link = 0; port_act = 0; error_cnt = 0; comparisons = 0; strobes = 0; trips = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("led_power", 1, led_power);
        rd(REG_CTRL, 32'h0, "ctrl");
        wr(REG_PATH, 32'h0003_6804);
        wr(REG_IRQ_MASK, 32'h0000_0002);
        wr(REG_CMD, 32'h0000_0040);
        chk("run_req", 1, run_req);
        repeat (20) @(posedge hclk);
        wr(REG_CMD, 32'h0000_0040);
        chk("strobes", 1, strobes);
        rd(REG_CMD, 32'h0000_0040, "cmd");
        wr(REG_CMD, 32'h0000_20c0);
        chk("motor_set_sel", 1, motor_set_sel);
        wr(REG_CMD, 32'h0000_20c0);
        chk("trips", 1, trips);
        chk("strobes", 2, strobes);
        rd(REG_IRQ_STAT, 32'h0000_000d, "irq_stat");
        wr(REG_CTRL, 32'h0000_0001);
        wr(REG_CMD, 32'h0000_0040);
        chk("irq", 1, irq);
        chk("motor_set_sel", 1, motor_set_sel);
        xfer(1'b0, REG_IRQ_STAT, 32'h0);
        chk("reject", 32'h2, q & 32'h2);
        wr(REG_CTRL, 32'h0000_0003);
        wr(REG_PATH, 32'h0103_6804);
        wr(REG_CMD, 32'h0000_0040);
        chk("motor_set_sel", 0, motor_set_sel);
        wr(REG_CTRL, 32'h0000_0043);
        rd(REG_CMD, 32'h0, "cmd_reinit");
        wr(REG_CMD, 32'h0000_0040);
        chk("strobes", 4, strobes);
        wr(REG_PATH, 32'h0003_6904);
        wr(REG_CMD, 32'h0000_0000);
        rd(REG_CMD, 32'h0000_0040, "cmd");
        repeat (10) @(posedge hclk);
        rd(REG_IMG_BASE, 32'h0000_0087, "word0");
        rd(REG_IMG_BASE + 4, 32'h0001_0d42, "current");
        rd(REG_IMG_BASE + 8, 32'h0000_1234, "trip_code");
        rd(32'h0000_001c, 32'h0, "unmapped");
        port_link <= 2'b10;
        wr(REG_CTRL, 32'h0000_0008);
        chk("led_error", 1, led_error);
        chk("led_link", 2'b10, led_link);
        wr(REG_CTRL, 32'h0000_0024);
        chk("led_status", 1, led_status);
        chk("led_error", 0, led_error);
        port_act <= 2'b01;
        wr(REG_CTRL, 32'h0000_0014);
        q = {28'h0, led_act, led_status, led_error};
        repeat (4) @(posedge hclk);
        chk("led_error", !q[0], led_error);
        chk("led_status", !q[1], led_status);
        chk("led_act", {1'b0, !q[2]}, led_act);
        chk("hresp", HRESP_OKAY, hresp);
        end_of_test;
    end
endmodule

// ### bench/fsca_starter_model.sv
`timescale 1ns/100ps
module fsca_starter_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic run_req,
    input  wire logic trip_reset,
    output logic      st_running,
    output logic      st_tripped,
    output logic      st_ready
);
    // powers up tripped so that a reset pulse has something to clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_running <= 1'b0;
            st_tripped <= 1'b1;
        end else begin
            st_running <= run_req;
            if (trip_reset)
                st_tripped <= 1'b0;
        end
    end
    assign st_ready = ~st_tripped;
endmodule

// ### include/fsca_mem_if.sv
`timescale 1ns/100ps
interface fsca_mem_if #(
    parameter int AW = 2,
    parameter int DW = 32
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### include/fsca_pkg.sv
package fsca_pkg;
    // clock and timing
    localparam int CLK_MHZ          = 10;
    localparam int MIN_INTERVAL_US  = 1000;
    localparam int CYC_INTERVAL     = MIN_INTERVAL_US * CLK_MHZ;
    localparam int FLASH_HALF_MS    = 250;
    localparam int FLASH_HALF_CYC   = FLASH_HALF_MS * 1000 * CLK_MHZ;
    localparam int ACT_HOLD_MS      = 50;
    localparam int ACT_HOLD_CYC     = ACT_HOLD_MS * 1000 * CLK_MHZ;
    localparam int CNT_W            = 24;

    // register byte addresses
    localparam logic [31:0] REG_CTRL     = 32'h0000_0000;
    localparam logic [31:0] REG_PATH     = 32'h0000_0004;
    localparam logic [31:0] REG_CMD      = 32'h0000_0008;
    localparam logic [31:0] REG_IMG_BASE = 32'h0000_0010;
    localparam logic [31:0] REG_IRQ_STAT = 32'h0000_0020;
    localparam logic [31:0] REG_IRQ_MASK = 32'h0000_0024;

    // object path of an access: class, instance, attribute, explicit flag
    localparam int PATH_W        = 25;
    localparam int PATH_CLASS_LSB = 0;
    localparam int PATH_INST_LSB  = 8;
    localparam int PATH_ATTR_LSB  = 16;
    localparam int PATH_EXPL_BIT  = 24;
    localparam logic [7:0] ASM_CLASS    = 8'h04;
    localparam logic [7:0] ASM_OUT_INST = 8'h68;
    localparam logic [7:0] ASM_IN_INST  = 8'h9a;
    localparam logic [7:0] ASM_ATTR     = 8'h03;

    // command image (4 bytes, little endian)
    localparam int CMD_RUN_BIT   = 6;
    localparam int CMD_RESET_BIT = 7;
    localparam int CMD_SET_BIT   = 13;
    localparam logic [31:0] CMD_RSVD_MASK = 32'hffff_df3f;

    // status image (12 bytes = 3 words, little endian)
    localparam int IMG_WORDS   = 3;
    localparam int IMG_AW      = 2;
    localparam int ST_READY    = 0;
    localparam int ST_OPMODE   = 1;
    localparam int ST_RUNNING  = 2;
    localparam int ST_TRIP     = 3;
    localparam int ST_WARN     = 7;
    localparam int ST_REMOTE   = 9;
    localparam int TRIP_CODE_W = 16;

    // control register bits
    localparam int CTRL_W        = 6;
    localparam int CTRL_REMOTE   = 0;
    localparam int CTRL_CIR_EN   = 1;
    localparam int CTRL_IP_OK    = 2;
    localparam int CTRL_DUP_IP   = 3;
    localparam int CTRL_TIMEOUT  = 4;
    localparam int CTRL_COMM_EST = 5;
    localparam int CTRL_REINIT   = 6;

    // interrupt status / mask bits
    localparam int IRQ_W      = 5;
    localparam int IRQ_FWD    = 0;
    localparam int IRQ_REJECT = 1;
    localparam int IRQ_TRIP   = 2;
    localparam int IRQ_FAST   = 3;
    localparam int IRQ_RSVD   = 4;

    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic {
        FSCA_BUS_READY = 1'b0,
        FSCA_BUS_IMG   = 1'b1
    } fsca_bus_st_t;
endpackage

// ### rtl/fsca_adapter.sv
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module fsca_adapter #(
    parameter int INTERVAL_CYCLES   = fsca_pkg::CYC_INTERVAL,
    parameter int FLASH_HALF_CYCLES = fsca_pkg::FLASH_HALF_CYC,
    parameter int ACT_HOLD_CYCLES   = fsca_pkg::ACT_HOLD_CYC,
    parameter int NPORTS            = 2
)(
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic [31:0]                          hrdata,
    output logic                                 hresp,
    output logic                                 irq,
    input  wire logic                            st_ready,
    input  wire logic                            st_op_mode,
    input  wire logic                            st_running,
    input  wire logic                            st_tripped,
    input  wire logic                            st_warning,
    input  wire logic                            st_remote,
    input  wire logic [31:0]                     st_current,
    input  wire logic [fsca_pkg::TRIP_CODE_W-1:0] st_trip_code,
    input  wire logic [NPORTS-1:0]               port_link,
    input  wire logic [NPORTS-1:0]               port_act,
    output logic                                 run_req,
    output logic                                 motor_set_sel,
    output logic                                 cmd_strobe,
    output logic                                 trip_reset,
    output logic                                 led_power,
    output logic                                 led_error,
    output logic                                 led_status,
    output logic [NPORTS-1:0]                    led_link,
    output logic [NPORTS-1:0]                    led_act
);
    import fsca_pkg::*;

    localparam int PIN_W = 6 + 32 + TRIP_CODE_W + 2 * NPORTS;

    fsca_mem_if #(.AW(IMG_AW), .DW(32)) img_if ();

    fsca_img_mem #(.DEPTH(IMG_WORDS), .AW(IMG_AW), .DW(32)) u_img (
        .hclk    (hclk),
        .hresetn (hresetn),
        .port    (img_if.mem)
    );

    function automatic logic is_img(input logic [31:0] a);
        return (a[31:4] == REG_IMG_BASE[31:4]) && (32'(a[3:2]) < IMG_WORDS);
    endfunction

    function automatic logic path_is(input logic [PATH_W-1:0] p, input logic [7:0] inst);
        return p[PATH_CLASS_LSB +: 8] == ASM_CLASS && p[PATH_INST_LSB +: 8] == inst
            && p[PATH_ATTR_LSB +: 8] == ASM_ATTR;
    endfunction

    // pin synchroniser: first stage only feeds the second
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;
    logic [PIN_W-1:0] pin_in;

    assign pin_in = {port_act, port_link, st_trip_code, st_current,
                     st_remote, st_warning, st_tripped, st_running, st_op_mode, st_ready};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    logic                    s_ready, s_op_mode, s_running, s_tripped, s_warning, s_remote;
    logic [31:0]             s_current;
    logic [TRIP_CODE_W-1:0]  s_trip_code;
    logic [NPORTS-1:0]       s_link;
    logic [NPORTS-1:0]       s_act;

    // multi-bit words land only when two samples in a row agree, so a word caught mid-change is never used
    localparam int WORD_W   = 32 + TRIP_CODE_W;
    localparam int WORD_LSB = PIN_W - 2 * NPORTS - WORD_W;

    logic [WORD_W-1:0] word_prev_r;
    logic [WORD_W-1:0] word_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_prev_r <= '0;
            word_r      <= '0;
        end else begin
            word_prev_r <= sync2_r[WORD_LSB +: WORD_W];
            if (word_prev_r == sync2_r[WORD_LSB +: WORD_W]) begin
                word_r <= word_prev_r;
            end
        end
    end

    assign {s_act, s_link, s_trip_code, s_current,
            s_remote, s_warning, s_tripped, s_running, s_op_mode, s_ready} =
           {sync2_r[PIN_W-1 -: 2 * NPORTS], word_r, sync2_r[WORD_LSB-1:0]};

    // bus slave
    fsca_bus_st_t       bus_st_r;
    logic               wr_ph_r;
    logic [31:0]        wr_addr_r;
    logic [CTRL_W-1:0]  ctrl_r;
    logic [PATH_W-1:0]  path_r;
    logic [31:0]        cmd_r;
    logic [IRQ_W-1:0]   irq_st_r;
    logic [IRQ_W-1:0]   mask_r;
    logic               ahb_take;
    logic               rd_irq;
    logic [31:0]        rd_word;

    assign ahb_take = hsel && htrans[1] && hready;
    assign rd_irq   = ahb_take && !hwrite && (haddr == REG_IRQ_STAT);

    always_comb begin
        unique case (haddr)
            REG_CTRL:     rd_word = 32'(ctrl_r);
            REG_PATH:     rd_word = 32'(path_r);
            REG_CMD:      rd_word = cmd_r;
            REG_IRQ_STAT: rd_word = 32'(irq_st_r);
            REG_IRQ_MASK: rd_word = 32'(mask_r);
            default:      rd_word = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st_r  <= FSCA_BUS_READY;
            hreadyout <= 1'b1;
            hrdata    <= '0;
            hresp     <= HRESP_OKAY;
            wr_ph_r   <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            hresp   <= HRESP_OKAY;
            wr_ph_r <= ahb_take && hwrite;
            if (ahb_take) begin
                wr_addr_r <= haddr;
            end
            unique case (bus_st_r)
                FSCA_BUS_READY: begin
                    if (ahb_take && !hwrite && is_img(haddr)) begin
                        bus_st_r  <= FSCA_BUS_IMG;
                        hreadyout <= 1'b0;
                    end else if (ahb_take && !hwrite) begin
                        hrdata <= rd_word;
                    end
                end
                FSCA_BUS_IMG: begin
                    bus_st_r  <= FSCA_BUS_READY;
                    hreadyout <= 1'b1;
                    hrdata    <= img_if.rd_data;
                end
            endcase
        end
    end

    // command path
    logic       cmd_wr, ctrl_wr, reinit, path_ok, allowed, cmd_acc, cmd_rej;
    logic       cmd_diff, trip_rise, too_fast, rsvd_set;
    logic       fwd_valid_r, gap_seen_r;
    logic [CNT_W-1:0] gap_cnt_r;

    assign cmd_wr    = wr_ph_r && (wr_addr_r == REG_CMD);
    assign ctrl_wr   = wr_ph_r && (wr_addr_r == REG_CTRL);
    assign reinit    = ctrl_wr && hwdata[CTRL_REINIT];
    assign path_ok   = path_is(path_r, ASM_OUT_INST);
    assign allowed   = !ctrl_r[CTRL_REMOTE] || ctrl_r[CTRL_CIR_EN];
    assign cmd_acc   = cmd_wr && path_ok && allowed;
    assign cmd_rej   = cmd_wr && !cmd_acc;
    assign cmd_diff  = !fwd_valid_r || (hwdata[CMD_RUN_BIT] != run_req)
                       || (hwdata[CMD_SET_BIT] != motor_set_sel);
    assign trip_rise = cmd_acc && hwdata[CMD_RESET_BIT] && !cmd_r[CMD_RESET_BIT];
    assign too_fast  = cmd_acc && !path_r[PATH_EXPL_BIT] && gap_seen_r
                       && (gap_cnt_r < CNT_W'(INTERVAL_CYCLES));
    assign rsvd_set  = cmd_acc && ((hwdata & CMD_RSVD_MASK) != '0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= '0;
            path_r <= '0;
            mask_r <= '0;
        end else if (wr_ph_r) begin
            if (wr_addr_r == REG_CTRL) begin
                ctrl_r <= hwdata[CTRL_W-1:0];
            end
            if (wr_addr_r == REG_PATH) begin
                path_r <= hwdata[PATH_W-1:0];
            end
            if (wr_addr_r == REG_IRQ_MASK) begin
                mask_r <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // held command image, 4 bytes, byte 0 in bits 7:0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_r <= '0;
        end else if (reinit) begin
            cmd_r <= '0;
        end else if (cmd_acc) begin
            cmd_r <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_req       <= 1'b0;
            motor_set_sel <= 1'b0;
            cmd_strobe    <= 1'b0;
            trip_reset    <= 1'b0;
            fwd_valid_r   <= 1'b0;
        end else begin
            cmd_strobe <= cmd_acc && cmd_diff;
            trip_reset <= trip_rise;
            if (reinit) begin
                fwd_valid_r <= 1'b0;
            end else if (cmd_acc && cmd_diff) begin
                fwd_valid_r   <= 1'b1;
                run_req       <= hwdata[CMD_RUN_BIT];
                motor_set_sel <= hwdata[CMD_SET_BIT];
            end
        end
    end

    // spacing between cyclic commands, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_cnt_r  <= '0;
            gap_seen_r <= 1'b0;
        end else if (cmd_acc && !path_r[PATH_EXPL_BIT]) begin
            gap_cnt_r  <= '0;
            gap_seen_r <= 1'b1;
        end else if (gap_cnt_r < CNT_W'(INTERVAL_CYCLES)) begin
            gap_cnt_r <= gap_cnt_r + 1'b1;
        end
    end

    // sticky events, cleared by reading; a new event wins over the clear
    logic [IRQ_W-1:0] ev;

    always_comb begin
        ev             = '0;
        ev[IRQ_FWD]    = cmd_acc && cmd_diff;
        ev[IRQ_REJECT] = cmd_rej;
        ev[IRQ_TRIP]   = trip_rise;
        ev[IRQ_FAST]   = too_fast;
        ev[IRQ_RSVD]   = rsvd_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_r <= '0;
            irq      <= 1'b0;
        end else begin
            irq_st_r <= (irq_st_r & ~{IRQ_W{rd_irq}}) | ev;
            irq      <= |(irq_st_r & mask_r);
        end
    end

    // status image refresh, one word per cycle, word 0 first, back to word 0 after word 2
    logic [IMG_AW-1:0] img_idx_r;
    logic [31:0]       img_word;

    always_comb begin
        img_word = '0;
        unique case (img_idx_r)
            2'h0: begin
                img_word[ST_READY]   = s_ready;
                img_word[ST_OPMODE]  = s_op_mode;
                img_word[ST_RUNNING] = s_running;
                img_word[ST_TRIP]    = s_tripped;
                img_word[ST_WARN]    = s_warning;
                img_word[ST_REMOTE]  = s_remote;
            end
            2'h1:    img_word = s_current;
            2'h2:    img_word = 32'(s_trip_code);
            default: img_word = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            img_idx_r <= '0;
        end else if (32'(img_idx_r) == IMG_WORDS - 1) begin
            img_idx_r <= '0;
        end else begin
            img_idx_r <= img_idx_r + 1'b1;
        end
    end

    assign img_if.wr_en   = 1'b1;
    assign img_if.wr_addr = img_idx_r;
    assign img_if.wr_data = img_word;
    assign img_if.rd_addr = haddr[3:2];

    // indicators
    logic [CNT_W-1:0] blink_cnt_r;
    logic             blink_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r == CNT_W'(FLASH_HALF_CYCLES - 1)) begin
            blink_cnt_r <= '0;
            blink_r     <= !blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_power  <= 1'b0;
            led_error  <= 1'b0;
            led_status <= 1'b0;
        end else begin
            led_power <= 1'b1;
            if (ctrl_r[CTRL_DUP_IP]) begin
                led_error <= 1'b1;
            end else begin
                led_error <= ctrl_r[CTRL_TIMEOUT] && blink_r;
            end
            if (ctrl_r[CTRL_COMM_EST]) begin
                led_status <= 1'b1;
            end else begin
                led_status <= ctrl_r[CTRL_IP_OK] && blink_r;
            end
        end
    end

    for (genvar g = 0; g < NPORTS; g++) begin : g_port
        logic [CNT_W-1:0] act_cnt_r;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                act_cnt_r   <= '0;
                led_link[g] <= 1'b0;
                led_act[g]  <= 1'b0;
            end else begin
                led_link[g] <= s_link[g];
                if (s_act[g]) begin
                    act_cnt_r <= CNT_W'(ACT_HOLD_CYCLES);
                end else if (act_cnt_r != '0) begin
                    act_cnt_r <= act_cnt_r - 1'b1;
                end
                led_act[g] <= (act_cnt_r != '0) && blink_r;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_cmd_blocked;
        cmd_wr && !allowed;
    endsequence

    sequence s_rej_seen;
        !cmd_strobe && irq_st_r[IRQ_REJECT];
    endsequence

    property p_remote_block;
        s_cmd_blocked |=> s_rej_seen;
    endproperty
    a_remote_block: assert property (p_remote_block) else $error("blocked command was forwarded");

    property p_path_gate;
        cmd_wr && !path_ok |=> $stable(cmd_r) && !cmd_strobe;
    endproperty
    a_path_gate: assert property (p_path_gate) else $error("command with wrong object path taken");

    property p_cmd_hold;
        !cmd_acc && !reinit |=> $stable(cmd_r);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("held command changed without a write");

    property p_trip_pulse;
        trip_rise |=> trip_reset ##1 (!trip_reset || $past(trip_rise));
    endproperty
    a_trip_pulse: assert property (p_trip_pulse) else $error("trip reset pulse wrong");

    property p_trip_cause;
        trip_reset |-> $past(cmd_acc) && !$past(cmd_r[CMD_RESET_BIT]);
    endproperty
    a_trip_cause: assert property (p_trip_cause) else $error("trip reset without a rising bit");

    property p_dedup;
        cmd_acc && fwd_valid_r && hwdata[CMD_RUN_BIT] == run_req
            && hwdata[CMD_SET_BIT] == motor_set_sel |=> !cmd_strobe && $stable(run_req);
    endproperty
    a_dedup: assert property (p_dedup) else $error("duplicate command forwarded");

    property p_run_set;
        cmd_strobe |-> run_req == $past(hwdata[CMD_RUN_BIT]) && motor_set_sel == $past(hwdata[CMD_SET_BIT]);
    endproperty
    a_run_set: assert property (p_run_set) else $error("forwarded run or set bit wrong");

    property p_fast_flag;
        cmd_acc && !path_r[PATH_EXPL_BIT] && gap_seen_r && gap_cnt_r >= CNT_W'(INTERVAL_CYCLES)
            |=> !irq_st_r[IRQ_FAST] || $past(irq_st_r[IRQ_FAST]);
    endproperty
    a_fast_flag: assert property (p_fast_flag) else $error("spacing flag raised at legal interval");

    property p_error_led;
        ctrl_r[CTRL_DUP_IP] [*2] |-> led_error;
    endproperty
    a_error_led: assert property (p_error_led) else $error("error lamp dark on duplicate address");

    property p_status_led;
        !ctrl_r[CTRL_COMM_EST] && !ctrl_r[CTRL_IP_OK] |=> !led_status;
    endproperty
    a_status_led: assert property (p_status_led) else $error("status lamp lit without address");

    property p_link_led;
        led_link == $past(port_link, 3);
    endproperty
    a_link_led: assert property (p_link_led) else $error("link lamp does not follow link");

    property p_irq_level;
        irq == |($past(irq_st_r) & $past(mask_r));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt output mismatch");
endmodule

// ### rtl/fsca_img_mem.sv
`timescale 1ns/100ps
module fsca_img_mem #(
    parameter int DEPTH = 3,
    parameter int AW    = 2,
    parameter int DW    = 32
)(
    input wire logic hclk,
    input wire logic hresetn,
    fsca_mem_if.mem  port
);
    logic [DW-1:0] mem_r [DEPTH];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (port.wr_en && (32'(port.wr_addr) < DEPTH)) begin
            mem_r[port.wr_addr] <= port.wr_data;
        end
    end

    // read data leaves through a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port.rd_data <= '0;
        end else if (32'(port.rd_addr) < DEPTH) begin
            port.rd_data <= mem_r[port.rd_addr];
        end else begin
            port.rd_data <= '0;
        end
    end
endmodule
